// [dv/splitter_assertions.sv]
// Checker on the shared PWM line and the splitter outputs
module splitter_assertions (
	input wire logic       ref_clk,
	input wire logic       rst_n,
	input wire logic       ctrlPwmO,
	input wire logic       ctrlPwmOe,
	input wire logic       devPwmO,
	input wire logic       devPwmOe,
	input wire logic       pwmLevel,
	input wire logic       phaseEnable,
	input wire logic       modeSelect,
	input wire logic [1:0] switchNodeHigh,
	input wire logic [1:0] highSideGate,
	input wire logic [1:0] lowSideGate,
	input wire logic [1:0] lowSideGateOe,
	input wire logic [1:0] sampleWindow
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****
	// Properties
	// ****
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	sequence s_low_off_a;
		$fell(lowSideGate[0]) && !devPwmOe;
	endsequence
	sequence s_window_edge_a;
		!sampleWindow[0] ##1 sampleWindow[0];
	endsequence
	a_line_held_high: assert property (devPwmOe |-> devPwmO && pwmLevel) else $error("line pull not high");
	a_shed_hold: assert property (devPwmOe && !phaseEnable |=> devPwmOe) else $error("pull dropped");
	a_shed_on_fall: assert property ($rose(devPwmOe) |-> !$past(phaseEnable) && !$past(pwmLevel))
		else $error("shed without disable and fall");
	a_shed_gates_off: assert property (devPwmOe |-> highSideGate == 2'h0 && lowSideGate == 2'h0)
		else $error("gate active while shed");
	a_release_line: assert property (devPwmOe && phaseEnable |=> !devPwmOe) else $error("line kept");
	a_wait_float: assert property ($fell(devPwmOe) |-> ##1 lowSideGateOe == switchNodeHigh
		&& lowSideGate == switchNodeHigh && highSideGate == 2'h0) else $error("low gate not floating");
	a_low_before_high: assert property ($rose(highSideGate[0]) |-> !$past(lowSideGate[0]))
		else $error("high on before low off");
	a_no_shoot: assert property ((highSideGate & lowSideGate & lowSideGateOe) == 2'h0)
		else $error("both gates on");
	// Shedding may cut a pending window, so it aborts the check
	a_window_open: assert property (disable iff (!rst_n || !phaseEnable)
		s_low_off_a |-> ##49 s_window_edge_a) else $error("window blanking wrong");
	a_window_max: assert property ($rose(sampleWindow[0]) |-> ##[1:100] !sampleWindow[0])
		else $error("window too long");
	a_window_cut: assert property ($rose(pwmLevel) && !devPwmOe |-> ##[1:4] sampleWindow == 2'h0)
		else $error("window not cut by rise");
	a_sync_both: assert property ($rose(highSideGate[0]) && modeSelect && $past(modeSelect, 4)
		|-> highSideGate[1]) else $error("sync pulse not on both");
	a_interleave_one: assert property ($rose(highSideGate[0]) && !modeSelect && !$past(modeSelect, 4)
		|-> !$rose(highSideGate[1])) else $error("interleaved pulse on both");
	a_ctrl_sheds: assert property (pwmLevel && ctrlPwmOe && !ctrlPwmO |-> ##[1:3] !ctrlPwmOe)
		else $error("controller kept phase");
endmodule // splitter_assertions

// [dv/tb.sv]
// Self-checking bench: splitter and controller facing each other
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import splitter_pkg::*;
	// ****
	// Signals
	// ****
	logic              ref_clk, rst_n, phaseEnable, modeSelect, pwmPrev, swapSeen;
	gain_t             gainStrap;
	logic [1:0]        switchNodeHigh, highSideGate, lowSideGate, lowSideGateOe, sampleWindow, hsPrev;
	logic [CUR_W-1:0]  senseCurrentA, senseCurrentB;
	logic              fireOrderSwapped, shedHigherPhases;
	logic [ADDR_W-1:0] awaddr, araddr;
	logic              awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [31:0]       wdata, rdata, rd, rng;
	logic [3:0]        wstrb;
	logic [1:0]        bresp, rresp, resp;
	int                errors, total_checks, cycles, pwmRises, hsA, hsB, fallA, fallB, dA, dB, ext;
	int                mul [3];
	int                shadow [$];
	splitter_if link();
	pwm_phase_splitter pwm_phase_splitter_i (.ref_clk(ref_clk), .rst_n(rst_n), .link(link),
		.phaseEnable(phaseEnable), .modeSelect(modeSelect), .gainStrap(gainStrap), .switchNodeHigh(switchNodeHigh),
		.senseCurrentA(senseCurrentA), .senseCurrentB(senseCurrentB), .highSideGate(highSideGate),
		.lowSideGate(lowSideGate), .lowSideGateOe(lowSideGateOe), .sampleWindow(sampleWindow),
		.fireOrderSwapped(fireOrderSwapped));
	pwm_shed_controller pwm_shed_controller_i (.ref_clk(ref_clk), .rst_n(rst_n), .link(link), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .shedHigherPhases(shedHigherPhases));
	splitter_assertions splitter_assertions_i (.ref_clk(ref_clk), .rst_n(rst_n), .ctrlPwmO(link.ctrlPwmO),
		.ctrlPwmOe(link.ctrlPwmOe), .devPwmO(link.devPwmO), .devPwmOe(link.devPwmOe), .pwmLevel(link.pwmLevel),
		.phaseEnable(phaseEnable), .modeSelect(modeSelect), .switchNodeHigh(switchNodeHigh),
		.highSideGate(highSideGate), .lowSideGate(lowSideGate), .lowSideGateOe(lowSideGateOe),
		.sampleWindow(sampleWindow));
	// ****
	// Tasks
	// ****
	function automatic logic [31:0] xs(input logic [31:0] v);
		v = v ^ (v << 13);
		v = v ^ (v >> 17);
		return v ^ (v << 5);
	endfunction
	task automatic complete_run;
		if (errors == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic axi_write(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge ref_clk);
		awaddr <= a; wdata <= d; wstrb <= 4'hF; awvalid <= 1'h1; wvalid <= 1'h1; bready <= 1'h1;
		forever begin
			@(posedge ref_clk);
			if (awvalid && awready) awvalid <= 1'h0;
			if (wvalid && wready) wvalid <= 1'h0;
			if (bvalid === 1'h1) begin r = bresp; bready <= 1'h0; break; end
		end
	endtask
	task automatic axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge ref_clk);
		araddr <= a; arvalid <= 1'h1; rready <= 1'h1;
		forever begin
			@(posedge ref_clk);
			if (arvalid && arready) arvalid <= 1'h0;
			if (rvalid === 1'h1) begin d = rdata; r = rresp; rready <= 1'h0; break; end
		end
	endtask
	// Snapshot after a rise has settled so each counted PWM rise owns its gate pulses
	task automatic run_pulses(input int n);
		int p, a, b;
		p = pwmRises;
		while (pwmRises == p) @(posedge ref_clk);
		repeat (8) @(posedge ref_clk);
		p = pwmRises; a = hsA; b = hsB;
		while (pwmRises < p + n) @(posedge ref_clk);
		repeat (8) @(posedge ref_clk);
		dA = hsA - a; dB = hsB - b;
	endtask
	// ****
	// Clock, monitors, sequence
	// ****
	initial begin
		ref_clk = 1'h0;
		forever #2 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		pwmPrev <= link.pwmLevel;
		hsPrev <= highSideGate;
		if (link.pwmLevel === 1'h1 && pwmPrev === 1'h0 && link.devPwmOe === 1'h0) pwmRises <= pwmRises + 1;
		if (highSideGate[0] && !hsPrev[0]) hsA <= hsA + 1;
		if (highSideGate[1] && !hsPrev[1]) hsB <= hsB + 1;
		if (!highSideGate[0] && hsPrev[0]) fallA <= cycles;
		if (!highSideGate[1] && hsPrev[1]) fallB <= cycles;
		if (fireOrderSwapped === 1'h1) swapSeen <= 1'h1;
		if (cycles == 40000) begin
			errors++;
			complete_run;
		end
	end
	initial begin
		rst_n = 1'h0; phaseEnable = 1'h1; modeSelect = 1'h0; gainStrap = GAIN_DEFAULT; switchNodeHigh = 2'h0;
		senseCurrentA = 8'h00; senseCurrentB = 8'h00; awaddr = 4'h0; araddr = 4'h0; wdata = 32'h0000_0000;
		wstrb = 4'h0; awvalid = 1'h0; wvalid = 1'h0; bready = 1'h0; arvalid = 1'h0; rready = 1'h0;
		errors = 0; total_checks = 0; cycles = 0; pwmRises = 0; hsA = 0; hsB = 0; swapSeen = 1'h0;
		rng = 32'h0000_0060; mul = '{int'(GAIN_MUL_DEF), int'(GAIN_MUL_HALF), int'(GAIN_MUL_FIFTH)};
		shadow = '{0, int'(PERIOD_RST), int'(DUTY_RST), 0};
		repeat (5) @(posedge ref_clk);
		rst_n <= 1'h1;
		axi_read(ADDR_CTRL, rd, resp); check("ctrl", shadow[ADDR_CTRL >> 2], rd);
		axi_read(ADDR_PERIOD, rd, resp); check("period", shadow[ADDR_PERIOD >> 2], rd);
		axi_read(ADDR_DUTY, rd, resp); check("duty", shadow[ADDR_DUTY >> 2], rd);
		axi_read(4'h2, rd, resp); check("bad read", {30'h0, RESP_SLVERR}, {rd[29:0], resp});
		axi_write(4'h2, 32'h0000_0001, resp); check("bad write", RESP_SLVERR, resp);
		axi_write(ADDR_STATUS, 32'hFFFF_FFFF, resp); check("status wr", RESP_OKAY, resp);
		axi_read(ADDR_STATUS, rd, resp); check("status idle", 32'h0000_0000, rd);
		axi_write(ADDR_PERIOD, 32'h0000_0078, resp); check("wr resp", RESP_OKAY, resp);
		shadow[ADDR_PERIOD >> 2] = 32'h0000_0078;
		axi_read(ADDR_PERIOD, rd, resp); check("period", shadow[ADDR_PERIOD >> 2], rd);
		axi_write(ADDR_CTRL, 32'h0000_0001, resp); check("run resp", RESP_OKAY, resp);
		shadow[ADDR_CTRL >> 2] = 1;
		axi_read(ADDR_CTRL, rd, resp); check("ctrl run", shadow[ADDR_CTRL >> 2], rd);
		for (int k = 0; k < 3; k++) begin
			rng = xs(rng); senseCurrentA <= {2'h0, rng[5:0]}; senseCurrentB <= {2'h0, rng[13:8]};
			run_pulses(8);
			check("alt a", 4, dA);
			check("alt b", 4, dB);
		end
		check("no swap", 0, swapSeen);
		modeSelect <= 1'h1;
		run_pulses(6);
		check("sync a", 6, dA);
		check("sync b", 6, dB);
		modeSelect <= 1'h0;
		run_pulses(6);
		check("back a", 3, dA);
		check("back b", 3, dB);
		axi_read(ADDR_STATUS, rd, resp); check("run stat", 32'h0000_0001 << STAT_DRIVE_BIT, rd);
		axi_write(ADDR_PERIOD, 32'h0000_00C8, resp); check("sync period", RESP_OKAY, resp);
		modeSelect <= 1'h1; senseCurrentA <= 8'h0A; senseCurrentB <= 8'h28;
		for (int g = 0; g < 3; g++) begin
			gainStrap <= gain_t'(g);
			run_pulses(4);
			ext = (30 * mul[g]) >> 4;
			check("extension", (ext > 31) ? 31 : ext, fallA - fallB);
		end
		modeSelect <= 1'h0; senseCurrentA <= 8'hC8; senseCurrentB <= 8'h0A;
		run_pulses(8);
		check("swap seen", 1, swapSeen);
		check("lighter more", 1, dB > dA);
		phaseEnable <= 1'h0;
		while (shedHigherPhases !== 1'h1) @(posedge ref_clk);
		axi_read(ADDR_STATUS, rd, resp); check("shed stat", 1, rd[STAT_SHED_BIT]);
		check("drive stat", 0, rd[STAT_DRIVE_BIT]);
		check("line high", 1, link.pwmLevel);
		check("gates", 0, {highSideGate, lowSideGate});
		switchNodeHigh <= 2'h2;
		phaseEnable <= 1'h1;
		while (shedHigherPhases !== 1'h0) @(posedge ref_clk);
		run_pulses(4);
		check("resumed", 4, dA + dB);
		switchNodeHigh <= 2'h0;
		complete_run;
	end
endmodule // tb

// [verilog/pwm_phase_splitter.sv]
// Device end: one PWM input split into two gate-drive channels
// Contract
// - Enable low: stop at next PWM fall
// - Then drive PWM line high while disabled
// - Controller drops phases when line held high
// - Re-enable: release line, resume at rise
// - Waiting: low gates floating unless node high
// - First phase splitter keeps enable tied high
// - Mode low interleaved, high synchronous
// - Mode pulse gives synchronous for its length
// - Strap selects default, half or fifth gain
// - Balance by widening lighter channel high pulse
// - Large imbalance swaps firing order fast
// - Sample window opens 200ns after low falls
// - Window ends after 400ns or PWM rise
// - System keeps sample windows 200ns or longer
// - Controller PWM rate follows the mode; here only the period register sets it, the controller never sees the mode
// - Interleaved 180 degrees apart, synchronous in phase
// - Low gate off before high gate on
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the address map.
module pwm_phase_splitter (
	input  wire logic                      ref_clk,
	input  wire logic                      rst_n,
	splitter_if.device                     link,
	input  wire logic                      phaseEnable,
	input  wire logic                      modeSelect,
	input  splitter_pkg::gain_t            gainStrap,
	input  wire logic [1:0]                switchNodeHigh,
	input  wire logic [splitter_pkg::CUR_W-1:0] senseCurrentA,
	input  wire logic [splitter_pkg::CUR_W-1:0] senseCurrentB,
	output logic [1:0]                     highSideGate,
	output logic [1:0]                     lowSideGate,
	output logic [1:0]                     lowSideGateOe,
	output logic [1:0]                     sampleWindow,
	output logic                           fireOrderSwapped
);
	import splitter_pkg::*;

	typedef enum logic [1:0] {ST_WAIT, ST_RUN, ST_SHED} link_st_t;

	link_st_t                 state_r;
	link_st_t                 state_nxt;
	logic                     pwmPrev_r;
	logic                     pwmHi;
	logic                     pwmRise;
	logic                     pwmFall;
	logic                     active;
	logic                     waiting;
	logic                     devDrive_r;
	logic                     lastB_r;
	logic                     swap_r;
	logic                     fireB;
	logic                     imbal;
	logic                     aHeavy;
	logic [CUR_W-1:0]         diffAB;
	logic [1:0]               sel_r;
	logic [1:0]               selNow;
	logic [GAIN_W-1:0]        gainMul;
	logic [CH_N-1:0][CUR_W-1:0] held;
	logic [CH_N-1:0][EXT_W-1:0] ext;

	// ****************************************
	// PWM edges and enable sequence
	// ****************************************
	assign pwmHi   = link.pwmLevel;
	assign pwmRise = pwmHi && !pwmPrev_r;
	assign pwmFall = !pwmHi && pwmPrev_r;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pwmPrev_r <= 1'b0;
		end else begin
			pwmPrev_r <= pwmHi;
		end
	end

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_RUN: begin
				if (!phaseEnable && pwmFall) begin
					state_nxt = ST_SHED;
				end
			end
			ST_SHED: begin
				if (phaseEnable) begin
					state_nxt = ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (pwmRise) begin
					state_nxt = ST_RUN;
				end
			end
			default: begin
				state_nxt = ST_WAIT;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= ST_WAIT;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Pull-up lands in the same edge that leaves the run state
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			devDrive_r <= 1'b0;
		end else begin
			devDrive_r <= (state_nxt == ST_SHED);
		end
	end

	assign link.devPwmO  = devDrive_r;
	assign link.devPwmOe = devDrive_r;
	assign active        = (state_nxt == ST_RUN);
	assign waiting       = (state_nxt == ST_WAIT);

	// ****************************************
	// Gain, balance and steering
	// ****************************************
	always_comb begin
		case (gainStrap)
			GAIN_HALF:  gainMul = GAIN_MUL_HALF;
			GAIN_FIFTH: gainMul = GAIN_MUL_FIFTH;
			default:    gainMul = GAIN_MUL_DEF;
		endcase
	end

	assign aHeavy = held[0] > held[1];
	assign diffAB = aHeavy ? (held[0] - held[1]) : (held[1] - held[0]);
	assign imbal  = diffAB > SWAP_THRESH;
	// Fast path overrides alternation, width trim still applies: the lighter channel fires next
	assign fireB  = imbal ? aHeavy : !lastB_r;
	assign selNow = modeSelect ? SEL_BOTH :
		(pwmRise ? (fireB ? SEL_B : SEL_A) : sel_r);

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sel_r   <= SEL_A;
			lastB_r <= 1'b1;
			swap_r  <= 1'b0;
		end else if (active && pwmRise) begin
			sel_r <= selNow;
			if (!modeSelect) begin
				lastB_r <= fireB;
				swap_r  <= (fireB == lastB_r);
			end
		end
	end

	assign fireOrderSwapped = swap_r;

	// ****************************************
	// Per-channel gate drive and sampling
	// ****************************************
	for (genvar ch = 0; ch < CH_N; ch++) begin : g_ch
		logic                    cmd;
		logic                    loNxt;
		logic                    hiOn_r;
		logic                    loOn_r;
		logic                    loOe_r;
		logic                    blank_r;
		logic                    samp_r;
		logic [CNT_W-1:0]        cnt_r;
		logic [EXT_W-1:0]        extCnt_r;
		logic [CUR_W-1:0]        held_r;
		logic [CUR_W-1:0]        cur;
		logic [CUR_W+GAIN_W-1:0] prod;
		logic [CUR_W+GAIN_W-1:0] scaled;

		assign cur = (ch == 0) ? senseCurrentA : senseCurrentB;
		assign cmd = active && pwmHi && selNow[ch];
		// Only the lighter channel gets its high pulse stretched
		assign prod = (held[CH_N-1-ch] > held_r) ?
			(CUR_W+GAIN_W)'(held[CH_N-1-ch] - held_r) * (CUR_W+GAIN_W)'(gainMul) : '0;
		assign scaled  = prod >> GAIN_SHIFT;
		assign ext[ch] = (scaled > (CUR_W+GAIN_W)'(EXT_MAX)) ? EXT_MAX : scaled[EXT_W-1:0];
		assign held[ch] = held_r;
		assign loNxt = active ? (!cmd && !hiOn_r) : (waiting && switchNodeHigh[ch]);

		always_ff @(posedge ref_clk or negedge rst_n) begin
			if (!rst_n) begin
				hiOn_r   <= 1'b0;
				extCnt_r <= '0;
			end else if (!active) begin
				hiOn_r   <= 1'b0;
				extCnt_r <= '0;
			end else if (cmd) begin
				extCnt_r <= ext[ch];
				hiOn_r   <= hiOn_r || !loOn_r;
			end else if (hiOn_r && extCnt_r != '0) begin
				extCnt_r <= extCnt_r - 1'b1;
			end else begin
				hiOn_r <= 1'b0;
			end
		end

		always_ff @(posedge ref_clk or negedge rst_n) begin
			if (!rst_n) begin
				loOn_r <= 1'b0;
				loOe_r <= 1'b0;
			end else begin
				loOn_r <= loNxt;
				// Floating while waiting guards against a shorted high-side FET
				loOe_r <= !waiting || switchNodeHigh[ch];
			end
		end

		always_ff @(posedge ref_clk or negedge rst_n) begin
			if (!rst_n) begin
				blank_r <= 1'b0;
				samp_r  <= 1'b0;
				cnt_r   <= '0;
			end else if (loOn_r && !loNxt) begin
				blank_r <= 1'b1;
				samp_r  <= 1'b0;
				cnt_r   <= CNT_W'(BLANK_CYC - 1);
			end else if (blank_r) begin
				if (cnt_r == '0) begin
					blank_r <= 1'b0;
					samp_r  <= 1'b1;
					cnt_r   <= CNT_W'(SAMP_CYC - 1);
				end else begin
					cnt_r <= cnt_r - 1'b1;
				end
			end else if (samp_r) begin
				if (cnt_r == '0 || pwmRise) begin
					samp_r <= 1'b0;
				end else begin
					cnt_r <= cnt_r - 1'b1;
				end
			end
		end

		always_ff @(posedge ref_clk or negedge rst_n) begin
			if (!rst_n) begin
				held_r <= '0;
			end else if (samp_r) begin
				held_r <= cur;
			end
		end

		assign highSideGate[ch]  = hiOn_r;
		assign lowSideGate[ch]   = loOn_r;
		assign lowSideGateOe[ch] = loOe_r;
		assign sampleWindow[ch]  = samp_r;
	end

endmodule // pwm_phase_splitter

// [verilog/pwm_shed_controller.sv]
// Controller end: PWM generator with shed detection and AXI4-Lite registers
module pwm_shed_controller (
	input  wire logic                          ref_clk,
	input  wire logic                          rst_n,
	splitter_if.controller                     link,
	input  wire logic [splitter_pkg::ADDR_W-1:0] awaddr,
	input  wire logic                          awvalid,
	output logic                               awready,
	input  wire logic [31:0]                   wdata,
	input  wire logic [3:0]                    wstrb,
	input  wire logic                          wvalid,
	output logic                               wready,
	output logic [1:0]                         bresp,
	output logic                               bvalid,
	input  wire logic                          bready,
	input  wire logic [splitter_pkg::ADDR_W-1:0] araddr,
	input  wire logic                          arvalid,
	output logic                               arready,
	output logic [31:0]                        rdata,
	output logic [1:0]                         rresp,
	output logic                               rvalid,
	input  wire logic                          rready,
	output logic                               shedHigherPhases
);
	import splitter_pkg::*;

	logic [ADDR_W-1:0] awAddr_r;
	logic [31:0]       wData_r;
	logic [3:0]        wStrb_r;
	logic              doWrite;
	logic [31:0]       ctrl_r;
	logic [31:0]       period_r;
	logic [31:0]       duty_r;
	logic [31:0]       cnt_r;
	logic              shed_r;
	logic              pwm_r;
	logic              oe_r;
	logic              drive;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (st[b]) begin
				res[8*b +: 8] = nw[8*b +: 8];
			end
		end
		return res;
	endfunction

	// ****************************************
	// AXI4-Lite write path
	// ****************************************
	assign doWrite = !awready && !wready && !bvalid;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			awready  <= 1'b1;
			awAddr_r <= '0;
		end else if (awvalid && awready) begin
			awready  <= 1'b0;
			awAddr_r <= awaddr;
		end else if (bvalid && bready) begin
			awready <= 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			wready  <= 1'b1;
			wData_r <= '0;
			wStrb_r <= '0;
		end else if (wvalid && wready) begin
			wready  <= 1'b0;
			wData_r <= wdata;
			wStrb_r <= wstrb;
		end else if (bvalid && bready) begin
			wready <= 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			bvalid <= 1'b0;
			bresp  <= RESP_OKAY;
		end else if (doWrite) begin
			bvalid <= 1'b1;
			bresp  <= (awAddr_r == ADDR_CTRL || awAddr_r == ADDR_PERIOD ||
				awAddr_r == ADDR_DUTY || awAddr_r == ADDR_STATUS) ? RESP_OKAY : RESP_SLVERR;
		end else if (bvalid && bready) begin
			bvalid <= 1'b0;
		end
	end

	// Status is read-only; a write to it is accepted and dropped
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_r   <= '0;
			period_r <= PERIOD_RST;
			duty_r   <= DUTY_RST;
		end else if (doWrite) begin
			case (awAddr_r)
				ADDR_CTRL:   ctrl_r <= merge(ctrl_r, wData_r, wStrb_r);
				ADDR_PERIOD: period_r <= merge(period_r, wData_r, wStrb_r);
				ADDR_DUTY:   duty_r <= merge(duty_r, wData_r, wStrb_r);
				default:     ctrl_r <= ctrl_r;
			endcase
		end
	end

	// ****************************************
	// AXI4-Lite read path
	// ****************************************
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
			rdata   <= '0;
			rresp   <= RESP_OKAY;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid  <= 1'b1;
			rresp   <= RESP_OKAY;
			case (araddr)
				ADDR_CTRL:   rdata <= ctrl_r;
				ADDR_PERIOD: rdata <= period_r;
				ADDR_DUTY:   rdata <= duty_r;
				ADDR_STATUS: begin
					rdata <= '0;
					rdata[STAT_SHED_BIT]  <= shed_r;
					rdata[STAT_DRIVE_BIT] <= oe_r;
				end
				default: begin
					rdata <= '0;
					rresp <= RESP_SLVERR;
				end
			endcase
		end else if (rvalid && rready) begin
			rvalid  <= 1'b0;
			arready <= 1'b1;
		end
	end

	// ****************************************
	// PWM generation and shedding
	// ****************************************
	assign drive = ctrl_r[CTRL_RUN_BIT] && !shed_r;

	// Driving low yet reading high means the splitter pulled the line up
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			shed_r <= 1'b0;
		end else if (oe_r && !pwm_r && link.pwmLevel) begin
			shed_r <= 1'b1;
		end else if (shed_r && link.pwmMid) begin
			shed_r <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= '0;
			pwm_r <= 1'b0;
			oe_r  <= 1'b0;
		end else if (!drive) begin
			cnt_r <= '0;
			pwm_r <= 1'b0;
			oe_r  <= 1'b0;
		end else begin
			cnt_r <= (cnt_r + 32'h0000_0001 >= period_r) ? '0 : cnt_r + 32'h0000_0001;
			pwm_r <= cnt_r < duty_r;
			oe_r  <= 1'b1;
		end
	end

	assign link.ctrlPwmO  = pwm_r;
	assign link.ctrlPwmOe = oe_r;
	assign shedHigherPhases = shed_r;

endmodule // pwm_shed_controller

// [verilog/splitter_if.sv]
// Shared PWM line between the controller and the splitter
interface splitter_if;
	logic ctrlPwmO;
	logic ctrlPwmOe;
	logic devPwmO;
	logic devPwmOe;
	logic pwmLevel;
	logic pwmMid;

	// ****************************************
	// Wire resolution
	// ****************************************
	// Splitter pull-up overrides the controller; nobody driving is mid-level
	assign pwmMid   = !devPwmOe && !ctrlPwmOe;
	assign pwmLevel = devPwmOe ? devPwmO : (ctrlPwmOe && ctrlPwmO);

	modport device (output devPwmO, output devPwmOe, input pwmLevel, input pwmMid);
	modport controller (output ctrlPwmO, output ctrlPwmOe, input pwmLevel, input pwmMid);
endinterface

// [verilog/splitter_pkg.sv]
// Shared constants and types for the PWM splitter and its controller
package splitter_pkg;
	// ****************************************
	// Timebase
	// ****************************************
	localparam int CLK_NS    = 4;
	localparam int BLANK_NS  = 200;
	localparam int SAMP_NS   = 400;
	// Least time rounds up, longest time rounds down
	localparam int BLANK_CYC = (BLANK_NS + CLK_NS - 1) / CLK_NS;
	localparam int SAMP_CYC  = SAMP_NS / CLK_NS;
	localparam int CNT_W     = 7;

	// ****************************************
	// Channels and balance
	// ****************************************
	localparam int CH_N      = 2;
	localparam int CUR_W     = 8;
	localparam int GAIN_W    = 4;
	localparam int GAIN_SHIFT = 4;
	localparam int EXT_W     = 5;
	localparam logic [EXT_W-1:0]  EXT_MAX     = 5'h1F;
	localparam logic [GAIN_W-1:0] GAIN_MUL_DEF = 4'hA;
	localparam logic [GAIN_W-1:0] GAIN_MUL_HALF = 4'h5;
	localparam logic [GAIN_W-1:0] GAIN_MUL_FIFTH = 4'h2;
	localparam logic [CUR_W-1:0]  SWAP_THRESH = 8'h40;
	localparam logic [1:0] SEL_A    = 2'h1;
	localparam logic [1:0] SEL_B    = 2'h2;
	localparam logic [1:0] SEL_BOTH = 2'h3;
	typedef enum logic [1:0] {GAIN_DEFAULT, GAIN_HALF, GAIN_FIFTH} gain_t;

	// ****************************************
	// Controller register map
	// ****************************************
	localparam int ADDR_W = 4;
	localparam logic [ADDR_W-1:0] ADDR_CTRL   = 4'h0;
	localparam logic [ADDR_W-1:0] ADDR_PERIOD = 4'h4;
	localparam logic [ADDR_W-1:0] ADDR_DUTY   = 4'h8;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'hC;
	localparam logic [31:0] PERIOD_RST = 32'h0000_0064;
	localparam logic [31:0] DUTY_RST   = 32'h0000_0014;
	localparam int CTRL_RUN_BIT = 0;
	localparam int STAT_SHED_BIT = 0;
	localparam int STAT_DRIVE_BIT = 1;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
